// File: include/usic_regs.svh
// Functional notes
// (R01) Software never writes 11 to the transmit interrupt mode field; it is reserved.
// (R02) Mode 10: interrupt when a load into the shifter empties the buffer.
// (R03) Mode 00: interrupt on every load of a character into the shifter.
// (R04) Mode 01: interrupt once the last character has fully left the shifter.
// (R05) No infrared, inversion set: transmit line idles low.
// (R06) Infrared, inversion set: encoded transmit output idles high.
// (R07) Inversion clear: line idles high, or encoded output idles low.
// (R08) Break bit: send start, twelve zeros, stop; hardware clears it after.
// (R09) Transmit enable set: port owns the transmit pin and transmits.
// (R10) Clearing transmit enable aborts sending, empties buffer, releases pin.
// (R11) Buffer full flag reads one when no transmit buffer slot is free.
// (R12) Shift-empty flag reads one only when shifter and buffer are empty.
// (R13) Shift-empty flag reads zero while shifting or characters wait.
// (R14) Receive mode 11: interrupt when a transfer makes four characters.
// (R15) Receive mode 10: interrupt when a transfer makes three characters.
// (R16) Receive mode 0x: interrupt on every received character transfer.
`ifndef USIC_REGS_SVH
`define USIC_REGS_SVH

// ---------------------------------------------------------------
// register word addresses
// ---------------------------------------------------------------
`define USIC_ADDR_STA     3'h0
`define USIC_ADDR_TXDATA  3'h1
`define USIC_ADDR_RXDATA  3'h2
`define USIC_ADDR_IRQ_ST  3'h3
`define USIC_ADDR_IRQ_CLR 3'h4
`define USIC_ADDR_IRQ_EN  3'h5

// ---------------------------------------------------------------
// status/control field positions
// ---------------------------------------------------------------
`define USIC_TXISEL1_BIT  15
`define USIC_INV_BIT      14
`define USIC_TXISEL0_BIT  13
`define USIC_BRK_BIT      11
`define USIC_TXEN_BIT     10
`define USIC_TXBF_BIT     9
`define USIC_TXEMPTY_BIT  8
`define USIC_RXISEL_HI    7
`define USIC_RXISEL_LO    6

// ---------------------------------------------------------------
// interrupt status bits, modes, sizes
// ---------------------------------------------------------------
`define USIC_IRQ_TX       0
`define USIC_IRQ_RX       1
`define USIC_TXI_ANY      2'h0
`define USIC_TXI_DONE     2'h1
`define USIC_TXI_EMPTY    2'h2
`define USIC_RXI_THREE    2'h2
`define USIC_RXI_FOUR     2'h3
`define USIC_FIFO_DEPTH   3'h4
`define USIC_CNT_THREE    3'h3
`define USIC_DATA_BITS    4'h8
`define USIC_BRK_BITS     4'hc

`endif

// File: include/usic_pkg.sv
package usic_pkg;
    typedef enum logic [1:0] {
        USIC_TX_IDLE,
        USIC_TX_START,
        USIC_TX_DATA,
        USIC_TX_STOP
    } usic_tx_state_t;
endpackage

// File: hdl/usic_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "usic_regs.svh"

module usic_core
    import usic_pkg::*;
(
    // clock, reset, enable
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       ce,
    // register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [15:0] reg_rdata,
    // bit timing and encoder
    input  wire logic       baud_tick,
    input  wire logic       infrared_encode_en,
    // receiver side
    input  wire logic       rx_word_valid,
    input  wire logic [7:0] rx_word_data,
    // transmit pin
    output logic            serial_tx_pin,
    output logic            serial_tx_pin_oe,
    // interrupt
    output logic            irq
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [1:0]     tx_irq_mode_sel_ff;
    logic           tx_polarity_invert_ff;
    logic           send_sync_break_ff;
    logic           transmit_enable_bit_ff;
    logic [1:0]     rx_irq_mode_sel_ff;
    logic [7:0]     tx_buf_ff [4];
    logic [1:0]     tx_rd_ptr_ff;
    logic [1:0]     tx_wr_ptr_ff;
    logic [2:0]     tx_cnt_ff;
    logic [7:0]     rx_buf_ff [4];
    logic [1:0]     rx_rd_ptr_ff;
    logic [1:0]     rx_wr_ptr_ff;
    logic [2:0]     rx_cnt_ff;
    usic_tx_state_t tx_state_ff;
    logic [7:0]     tx_shift_ff;
    logic [3:0]     tx_bit_cnt_ff;
    logic           tx_is_brk_ff;
    logic [1:0]     irq_status_ff;
    logic [1:0]     irq_enable_ff;
    logic [15:0]    reg_rdata_ff;
    logic           tx_line_ff;

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    // every strobe is qualified by ce here, so a frozen block neither
    // takes writes nor pops the receive buffer
    wire wr_sta    = ce & reg_wr & (reg_addr == `USIC_ADDR_STA);
    wire wr_txdata = ce & reg_wr & (reg_addr == `USIC_ADDR_TXDATA);
    wire wr_clr    = ce & reg_wr & (reg_addr == `USIC_ADDR_IRQ_CLR);
    wire wr_en     = ce & reg_wr & (reg_addr == `USIC_ADDR_IRQ_EN);
    wire rd_rxdata = ce & reg_rd & (reg_addr == `USIC_ADDR_RXDATA);

    // a write that clears enable also kills the buffer in the same edge
    wire txen_next = wr_sta ? reg_wdata[`USIC_TXEN_BIT] : transmit_enable_bit_ff;
    wire tx_kill   = ~txen_next; // [R10]

    // ---------------------------------------------------------------
    // transmit status flags
    // ---------------------------------------------------------------
    // flags are pure decode of count and shifter state, so full and
    // shift-empty can never both read one
    wire tx_full  = (tx_cnt_ff == `USIC_FIFO_DEPTH); // [R11]
    wire tx_idle  = (tx_state_ff == USIC_TX_IDLE);
    wire tx_shift_empty_flag = tx_idle & (tx_cnt_ff == 3'h0); // [R12] [R13]

    // writes to a full buffer are dropped rather than overwrite a waiting character
    wire tx_push  = wr_txdata & ~tx_full & ~tx_kill;

    // shifter takes a break first, otherwise the next waiting character
    wire brk_go   = ce & transmit_enable_bit_ff & tx_idle & send_sync_break_ff
                    & ~tx_kill; // [R08]
    wire tx_load  = ce & transmit_enable_bit_ff & tx_idle & ~send_sync_break_ff
                    & (tx_cnt_ff != 3'h0) & ~tx_kill; // [R09]
    wire tx_step  = ce & baud_tick & ~tx_idle & ~tx_kill;
    wire tx_last  = (tx_bit_cnt_ff == (tx_is_brk_ff ? `USIC_BRK_BITS : `USIC_DATA_BITS));
    wire tx_end   = tx_step & (tx_state_ff == USIC_TX_STOP);

    wire [2:0] tx_cnt_after = tx_cnt_ff + {2'h0, tx_push} - {2'h0, tx_load};

    // ---------------------------------------------------------------
    // transmit interrupt source, mode 11 never fires
    // ---------------------------------------------------------------
    // each source is a one-cycle pulse into the sticky status bit; the
    // empty test uses the count after this edge, so a push in the load
    // cycle rightly holds back the mode 10 event
    wire txi_any   = tx_load & (tx_irq_mode_sel_ff == `USIC_TXI_ANY); // [R03]
    wire txi_empty = tx_load & (tx_irq_mode_sel_ff == `USIC_TXI_EMPTY)
                     & (tx_cnt_after == 3'h0); // [R02]
    wire txi_done  = tx_end & (tx_irq_mode_sel_ff == `USIC_TXI_DONE)
                     & (tx_cnt_ff == 3'h0) & ~tx_push; // [R04]
    wire tx_event  = txi_any | txi_empty | txi_done; // [R01]

    // ---------------------------------------------------------------
    // receive buffer and interrupt source
    // ---------------------------------------------------------------
    // thresholds compare the count after the push, so they fire once, on
    // the transfer that reaches them, and not again while it sits there
    wire rx_full   = (rx_cnt_ff == `USIC_FIFO_DEPTH);
    wire rx_push   = ce & rx_word_valid & ~rx_full;
    wire rx_pop    = rd_rxdata & (rx_cnt_ff != 3'h0);
    wire [2:0] rx_cnt_after = rx_cnt_ff + {2'h0, rx_push} - {2'h0, rx_pop};
    wire rxi_any   = rx_push & ~rx_irq_mode_sel_ff[1]; // [R16]
    wire rxi_three = rx_push & (rx_irq_mode_sel_ff == `USIC_RXI_THREE)
                     & (rx_cnt_after == `USIC_CNT_THREE); // [R15]
    wire rxi_four  = rx_push & (rx_irq_mode_sel_ff == `USIC_RXI_FOUR)
                     & (rx_cnt_after == `USIC_FIFO_DEPTH); // [R14]
    wire rx_event  = rxi_any | rxi_three | rxi_four;

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    // unmapped and write-only words read zero; bit 12 and the receive
    // error bits are not kept in this block and read zero too
    wire [15:0] sta_word = {tx_irq_mode_sel_ff[1], tx_polarity_invert_ff,
                            tx_irq_mode_sel_ff[0], 1'b0, send_sync_break_ff,
                            transmit_enable_bit_ff, tx_full, tx_shift_empty_flag,
                            rx_irq_mode_sel_ff, 6'h00};
    wire [15:0] nxt_reg_rdata =
        (reg_addr == `USIC_ADDR_STA)    ? sta_word :
        (reg_addr == `USIC_ADDR_RXDATA) ? {8'h00, rx_buf_ff[rx_rd_ptr_ff]} :
        (reg_addr == `USIC_ADDR_IRQ_ST) ? {14'h0000, irq_status_ff} :
        (reg_addr == `USIC_ADDR_IRQ_EN) ? {14'h0000, irq_enable_ff} : 16'h0000;

    // ---------------------------------------------------------------
    // line level, idle and polarity
    // ---------------------------------------------------------------
    // raw mark level 1 means idle/stop; encoder path gets the raw bit, idle
    // level follows the inversion bit, plain path inverts the whole line
    // with the encoder on, inversion only picks the idle level; the
    // encoder shapes the pulses itself, so frames go out uninverted
    wire raw_bit = (tx_state_ff == USIC_TX_START) ? 1'b0 :
                   (tx_state_ff == USIC_TX_DATA)  ? (~tx_is_brk_ff & tx_shift_ff[0]) :
                   1'b1;
    wire nxt_tx_line = infrared_encode_en
                     ? (tx_idle ? tx_polarity_invert_ff : raw_bit) // [R06] [R07]
                     : (raw_bit ^ tx_polarity_invert_ff); // [R05] [R07]

    assign serial_tx_pin    = tx_line_ff;
    assign serial_tx_pin_oe = transmit_enable_bit_ff; // [R09] [R10]
    assign reg_rdata        = reg_rdata_ff;
    assign irq              = |(irq_status_ff & irq_enable_ff);

    // ---------------------------------------------------------------
    // control register
    // ---------------------------------------------------------------
    // break bit set by software, cleared when its stop bit ends
    // software can only raise the request; a write that lands on the
    // edge ending the break frame must not keep the old request, or a
    // second break would follow that nobody asked for
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_irq_mode_sel_ff     <= 2'h0;
            tx_polarity_invert_ff  <= 1'b0;
            send_sync_break_ff     <= 1'b0;
            transmit_enable_bit_ff <= 1'b0;
            rx_irq_mode_sel_ff     <= 2'h0;
        end else if (wr_sta) begin
            tx_irq_mode_sel_ff     <= {reg_wdata[`USIC_TXISEL1_BIT],
                                       reg_wdata[`USIC_TXISEL0_BIT]};
            tx_polarity_invert_ff  <= reg_wdata[`USIC_INV_BIT];
            send_sync_break_ff     <= reg_wdata[`USIC_BRK_BIT]
                                      | (send_sync_break_ff & ~(tx_end & tx_is_brk_ff)); // [R08]
            transmit_enable_bit_ff <= reg_wdata[`USIC_TXEN_BIT];
            rx_irq_mode_sel_ff     <= reg_wdata[`USIC_RXISEL_HI:`USIC_RXISEL_LO];
        end else if (tx_end & tx_is_brk_ff) begin
            send_sync_break_ff     <= 1'b0; // [R08]
        end
    end

    // ---------------------------------------------------------------
    // transmit buffer
    // ---------------------------------------------------------------
    // abort wins over pushes and loads, so re-enabling always starts from
    // an empty buffer with both pointers at slot zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_rd_ptr_ff <= 2'h0;
            tx_wr_ptr_ff <= 2'h0;
            tx_cnt_ff    <= 3'h0;
        end else if (ce & tx_kill) begin
            tx_rd_ptr_ff <= 2'h0; // [R10]
            tx_wr_ptr_ff <= 2'h0;
            tx_cnt_ff    <= 3'h0;
        end else if (ce) begin
            tx_rd_ptr_ff <= tx_rd_ptr_ff + {1'b0, tx_load};
            tx_wr_ptr_ff <= tx_wr_ptr_ff + {1'b0, tx_push};
            tx_cnt_ff    <= tx_cnt_after;
        end
    end

    // buffer storage needs no reset, pointers guard it
    always_ff @(posedge clk_sys) begin
        if (tx_push) begin
            tx_buf_ff[tx_wr_ptr_ff] <= reg_wdata[7:0];
        end
        if (rx_push) begin
            rx_buf_ff[rx_wr_ptr_ff] <= rx_word_data;
        end
    end

    // ---------------------------------------------------------------
    // transmit shifter
    // ---------------------------------------------------------------
    // a start bit begins at the load edge and ends at the next bit tick,
    // since bit timing lives outside; limitation: a start bit comes out at least
    // one clock shorter than a full bit time unless the load edge falls on a bit tick
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_state_ff   <= USIC_TX_IDLE;
            tx_shift_ff   <= 8'h00;
            tx_bit_cnt_ff <= 4'h0;
            tx_is_brk_ff  <= 1'b0;
        end else if (ce & tx_kill) begin
            tx_state_ff   <= USIC_TX_IDLE; // [R10]
            tx_is_brk_ff  <= 1'b0;
        end else if (brk_go | tx_load) begin
            tx_state_ff   <= USIC_TX_START;
            tx_shift_ff   <= brk_go ? 8'h00 : tx_buf_ff[tx_rd_ptr_ff];
            tx_bit_cnt_ff <= 4'h0;
            tx_is_brk_ff  <= brk_go; // [R08]
        end else if (tx_step) begin
            unique case (tx_state_ff)
                USIC_TX_IDLE: begin
                    tx_state_ff <= USIC_TX_IDLE;
                end
                USIC_TX_START: begin
                    tx_state_ff   <= USIC_TX_DATA;
                    tx_bit_cnt_ff <= 4'h1;
                end
                USIC_TX_DATA: begin
                    if (tx_last) begin
                        tx_state_ff <= USIC_TX_STOP;
                    end else begin
                        tx_bit_cnt_ff <= tx_bit_cnt_ff + 4'h1;
                        tx_shift_ff   <= {1'b0, tx_shift_ff[7:1]};
                    end
                end
                USIC_TX_STOP: begin
                    tx_state_ff  <= USIC_TX_IDLE;
                    tx_is_brk_ff <= 1'b0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // receive buffer pointers
    // ---------------------------------------------------------------
    // a character arriving with the buffer full is lost, the count holds
    // overrun is not flagged here; the receive error bits live elsewhere
    // so software only sees it as a missing character
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_rd_ptr_ff <= 2'h0;
            rx_wr_ptr_ff <= 2'h0;
            rx_cnt_ff    <= 3'h0;
        end else if (ce) begin
            rx_rd_ptr_ff <= rx_rd_ptr_ff + {1'b0, rx_pop};
            rx_wr_ptr_ff <= rx_wr_ptr_ff + {1'b0, rx_push};
            rx_cnt_ff    <= rx_cnt_after;
        end
    end

    // ---------------------------------------------------------------
    // interrupt status, enable, read data, line
    // ---------------------------------------------------------------
    // a new event in the clear cycle wins over the clear
    // read data fall back to zero after one cycle so an idle bus reads zero;
    // the line is registered so decode glitches never reach the pin
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_status_ff <= 2'h0;
            irq_enable_ff <= 2'h0;
            reg_rdata_ff  <= 16'h0000;
            tx_line_ff    <= 1'b1;
        end else if (ce) begin
            irq_status_ff <= (irq_status_ff & ~(wr_clr ? reg_wdata[1:0] : 2'h0))
                             | {rx_event, tx_event};
            if (wr_en) begin
                irq_enable_ff <= reg_wdata[1:0];
            end
            reg_rdata_ff  <= reg_rd ? nxt_reg_rdata : 16'h0000;
            tx_line_ff    <= nxt_tx_line;
        end
    end

endmodule
`default_nettype wire

// File: bench/usic_core_checker.sv
`timescale 1ns/1ns
`default_nettype none
module usic_core_checker
    import usic_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        ce,
    // register port
    input wire logic [2:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // line side
    input wire logic        infrared_encode_en,
    input wire logic        rx_word_valid,
    input wire logic        serial_tx_pin,
    input wire logic        serial_tx_pin_oe,
    input wire logic        irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ---------------------------------------------------------------
    // shadow of what software should see
    // ---------------------------------------------------------------
    logic [15:0] ctl_ff;    // control fields as last written
    logic [1:0]  irq_en_ff;
    logic [2:0]  rx_cnt_ff;
    logic        rx_st_ff;
    logic [1:0]  quiet_ff;  // saturating count since the last control write
    wire         wr_ctl  = ce && reg_wr && reg_addr == 3'h0;
    wire         rx_take = ce && rx_word_valid && rx_cnt_ff != 3'h4;
    wire         rx_pop  = ce && reg_rd && reg_addr == 3'h2 && rx_cnt_ff != 3'h0;
    wire [2:0]   rx_new  = rx_cnt_ff + {2'h0, rx_take} - {2'h0, rx_pop};
    wire         rx_evt  = rx_take && (!ctl_ff[7] || rx_new == (ctl_ff[6] ? 3'h4 : 3'h3));
    wire         rx_clr  = ce && reg_wr && reg_addr == 3'h4 && reg_wdata[1];
    // a status set beats a clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctl_ff    <= 16'h0;
            irq_en_ff <= 2'h0;
            rx_cnt_ff <= 3'h0;
            rx_st_ff  <= 1'b0;
            quiet_ff  <= 2'h0;
        end else begin
            if (wr_ctl) ctl_ff <= reg_wdata & 16'he4c0;
            if (ce && reg_wr && reg_addr == 3'h5) irq_en_ff <= reg_wdata[1:0];
            rx_cnt_ff <= rx_new;
            rx_st_ff  <= rx_evt || (rx_st_ff && !rx_clr);
            quiet_ff  <= wr_ctl ? 2'h0 : quiet_ff + {1'b0, quiet_ff != 2'h3};
        end
    end
    sequence s_rd(logic [2:0] a); ce && reg_rd && reg_addr == a; endsequence
    sequence s_off; !serial_tx_pin_oe [*2]; endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("read data outside a read answer");
    a_unmapped_read: assert property (ce && reg_rd && reg_addr > 3'h5 |=> reg_rdata == 16'h0)
        else $error("unmapped read not zero");
    a_ctl_fields: assert property (s_rd(3'h0) |=> (reg_rdata & 16'hf4ff) == $past(ctl_ff))
        else $error("control fields read back wrong");
    a_full_empty: assert property (s_rd(3'h0) |=> !(reg_rdata[9] && reg_rdata[8]))
        else $error("full and shift-empty both set");
    a_abort_flags: assert property (s_off ##0 s_rd(3'h0) |=> reg_rdata[9:8] == 2'h1)
        else $error("flags wrong while transmit is off");
    a_pin_owner: assert property (wr_ctl |=> serial_tx_pin_oe == $past(reg_wdata[10]))
        else $error("pin ownership wrong");
    a_idle_level: assert property (!serial_tx_pin_oe && quiet_ff == 2'h3 &&
        $stable(infrared_encode_en) |-> serial_tx_pin == (infrared_encode_en ^ !ctl_ff[14]))
        else $error("idle line level wrong");
    a_rx_status: assert property (s_rd(3'h3) |=> reg_rdata[1] == $past(rx_st_ff))
        else $error("receive event status wrong");
    a_rx_irq: assert property (rx_st_ff && irq_en_ff[1] |-> irq)
        else $error("enabled receive event without interrupt");
endmodule
bind usic_core usic_core_checker usic_core_checker_inst (.*);
`default_nettype wire

// File: bench/usic_remote_rx.sv
`timescale 1ns/1ns
`default_nettype none
// listens on the transmit line as the remote receiver; idle is taken as high
module usic_remote_rx (
    // timing and line
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       baud_tick,
    input  wire logic       line,
    // what was heard
    output logic      [7:0] last_char,
    output logic      [7:0] n_frames,
    output logic      [4:0] last_low
);
    logic [3:0] bit_ff;  // 0 idle, 1-8 data, 9 stop, 10 wait for a high line
    logic [7:0] sh_ff;
    logic [4:0] run_ff;  // low samples in a row, so a break shows its length
    // a tick closes the bit the line carried since the previous one
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bit_ff   <= 4'h0;
            run_ff   <= 5'h0;
            n_frames <= 8'h0;
            last_low <= 5'h0;
        end else if (baud_tick) begin
            run_ff <= line ? 5'h0 : run_ff + 5'h1;
            if (line && run_ff != 5'h0) last_low <= run_ff;
            if (bit_ff == 4'h0 && !line) bit_ff <= 4'h1;
            else if (bit_ff >= 4'h1 && bit_ff <= 4'h8) begin
                sh_ff  <= {line, sh_ff[7:1]};
                bit_ff <= bit_ff + 4'h1;
            end else if (bit_ff == 4'h9) begin
                bit_ff    <= line ? 4'h0 : 4'ha;
                last_char <= line ? sh_ff : last_char;
                n_frames  <= n_frames + {7'h0, line};
            end else if (bit_ff == 4'ha && line) bit_ff <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// File: bench/test_usic_core.sv
`timescale 1ns/1ns
`default_nettype none
module test_usic_core;
    import usic_pkg::*;
    logic        clk_sys, rst, reg_wr, reg_rd, infrared_encode_en, rx_word_valid;
    logic        serial_tx_pin, serial_tx_pin_oe, irq;
    logic        baud_tick = 1'b0;
    logic        ce = 1'b1;  // freezing is not exercised here
    logic [2:0]  reg_addr, tick_cnt = 3'h0;
    logic [15:0] reg_wdata, reg_rdata;
    logic [7:0]  rx_word_data, rm_char, rm_frames;
    logic [4:0]  rm_low;
    logic [1:0]  md;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    usic_core usic_core_inst (.*);
    usic_remote_rx usic_remote_rx_inst (.clk_sys(clk_sys), .rst(rst), .baud_tick(baud_tick),
        .line(serial_tx_pin | !serial_tx_pin_oe),  // a released pin is seen as high by the remote receiver
        .last_char(rm_char), .n_frames(rm_frames), .last_low(rm_low));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // a bit time every eight clocks; the cycle count cuts a hang short
    always @(posedge clk_sys) begin
        tick_cnt  <= tick_cnt + 3'h1;
        baud_tick <= tick_cnt == 3'h7;
        cyc       <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (n_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one access: write d, or read and compare the bits under m with d
    task automatic acc(input logic rd, input logic [2:0] a, input logic [15:0] d,
                       input logic [15:0] m = 16'hffff);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= !rd;
        reg_rd    <= rd;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        #1;
        if (rd) chk(reg_rdata & m, d);
    endtask
    initial begin
        {reg_wr, reg_rd, rx_word_valid, infrared_encode_en} = 4'h0;
        {reg_addr, reg_wdata, rx_word_data} = 27'h0;
        rst = 1'b1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        acc(1, 3'h0, 16'h0100);
        acc(1, 3'h6, 16'h0000);
        acc(0, 3'h5, 16'h0003);
        // receive modes 0x, 10, 11: four words in, then popped in order
        for (int m = 0; m < 3; m++) begin
            md = (m == 0) ? 2'h0 : 2'(m + 1);
            acc(0, 3'h0, {8'h0, md, 6'h0});
            acc(0, 3'h4, 16'h0003);
            for (int k = 1; k < 5; k++) begin
                @(posedge clk_sys);
                rx_word_valid <= 1'b1;
                rx_word_data  <= 8'(k);
                @(posedge clk_sys);
                rx_word_valid <= 1'b0;
                acc(1, 3'h3, (md < 2 || k > md) ? 16'h2 : 16'h0, 16'h2);
            end
            for (int k = 1; k < 5; k++) acc(1, 3'h2, 16'(k), 16'h00ff);
        end
        // transmit modes; the reserved encoding is never written
        acc(0, 3'h0, 16'h0400);
        acc(0, 3'h4, 16'h0003);
        acc(0, 3'h1, 16'h005a);
        acc(1, 3'h3, 16'h0001, 16'h0001);
        acc(1, 3'h0, 16'h0000, 16'h0100);
        while (rm_frames < 8'h1) @(posedge clk_sys);
        chk({8'h0, rm_char}, 16'h005a);
        chk({15'h0, serial_tx_pin_oe}, 16'h0001);
        acc(1, 3'h0, 16'h0100, 16'h0300);
        acc(0, 3'h0, 16'h8400);
        for (int k = 1; k < 6; k++) acc(0, 3'h1, 16'(k));
        acc(0, 3'h4, 16'h0003);
        acc(1, 3'h0, 16'h0200, 16'h0200);
        while (rm_frames < 8'h4) @(posedge clk_sys);
        acc(1, 3'h3, 16'h0000, 16'h0001);
        chk({15'h0, irq}, 16'h0000);
        acc(1, 3'h0, 16'h0000, 16'h0300);
        while (rm_frames < 8'h5) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        acc(1, 3'h3, 16'h0001, 16'h0001);
        chk({15'h0, irq}, 16'h0001);
        while (rm_frames < 8'h6) @(posedge clk_sys);
        chk({8'h0, rm_char}, 16'h0005);
        acc(0, 3'h0, 16'h2400);
        acc(0, 3'h4, 16'h0003);
        acc(0, 3'h1, 16'h00a5);
        acc(1, 3'h3, 16'h0000, 16'h0001);
        while (rm_frames < 8'h7) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        acc(1, 3'h3, 16'h0001, 16'h0001);
        // sync break lasts thirteen bit times, then the request bit drops
        acc(0, 3'h0, 16'h0c00);
        repeat (130) @(posedge clk_sys);
        chk({11'h0, rm_low}, 16'h000d);
        acc(1, 3'h0, 16'h0100, 16'h0900);
        // abort in mid-frame with a character still queued
        acc(0, 3'h1, 16'h0011);
        acc(0, 3'h1, 16'h0022);
        repeat (20) @(posedge clk_sys);
        acc(0, 3'h0, 16'h0000);
        acc(1, 3'h0, 16'h0100, 16'h0300);
        chk({15'h0, serial_tx_pin}, 16'h0001);
        chk({15'h0, serial_tx_pin_oe}, 16'h0000);
        // idle levels for each mix of inversion and encoder
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            infrared_encode_en <= i[1];
            acc(0, 3'h0, i[0] ? 16'h4000 : 16'h0000);
            repeat (2) @(posedge clk_sys);
            #1;
            chk({15'h0, serial_tx_pin}, {15'h0, i[1] ? i[0] : !i[0]});
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
